// ==== design/rsix_defines.svh ====
`ifndef RSIX_DEFINES_SVH
`define RSIX_DEFINES_SVH

// Register offsets
`define RSIX_ADDR_CTRL      16'h4077
`define RSIX_ADDR_ON        16'h4078
`define RSIX_ADDR_SLEEP     16'h4079
`define RSIX_ADDR_IRQ_STAT  16'h4080
`define RSIX_ADDR_IRQ_MASK  16'h4081

// Reset values and writable bits
`define RSIX_CTRL_RST       16'h0200
`define RSIX_ON_RST         16'h0000
`define RSIX_SLEEP_RST      16'h0100
`define RSIX_CTRL_WMASK     16'hdfc1
`define RSIX_SLOT_WMASK     16'he11f

// Control register fields
`define RSIX_ACT_HI         15
`define RSIX_ACT_LO         14
`define RSIX_SRC_HI         12
`define RSIX_SRC_LO         11
`define RSIX_HVSEL_BIT      10
`define RSIX_HMODE_HI       9
`define RSIX_HMODE_LO       8
`define RSIX_FLT_BIT        7
`define RSIX_SWI_BIT        6
`define RSIX_LPV_BIT        0

// ON and SLEEP register fields
`define RSIX_SLOT_HI        15
`define RSIX_SLOT_LO        13
`define RSIX_MODE_BIT       8
`define RSIX_VSEL_HI        4
`define RSIX_VSEL_LO        0

// Voltage encoding in millivolts
`define RSIX_V_BASE_LO      12'd900
`define RSIX_V_STEP_LO      12'd50
`define RSIX_V_BASE_HI      12'd1700
`define RSIX_V_STEP_HI      12'd100
`define RSIX_V_KNEE         5'h0f

`endif

// ==== design/rsix_pkg.sv ====
package rsix_pkg;

  // Regulator power state
  typedef enum logic [1:0] {
    RSIX_OFF,
    RSIX_ON,
    RSIX_TRIPPED
  } rsix_state_t;

  // Undervoltage action codes
  typedef enum logic [1:0] {
    RSIX_ACT_IGNORE = 2'h0,
    RSIX_ACT_SHUT   = 2'h1,
    RSIX_ACT_RESET  = 2'h2,
    RSIX_ACT_RSVD   = 2'h3
  } rsix_act_t;

endpackage : rsix_pkg

// ==== design/rsix_irq_if.sv ====
`timescale 1ns/1ps
// Event, clear and mask traffic to the interrupt unit
interface rsix_irq_if;
  logic [1:0] evt;     // Event pulses
  logic [1:0] clr;     // Write-one-to-clear pulses
  logic       mask_we; // Mask write strobe
  logic [1:0] mask_wd; // Mask write data
  logic [1:0] status;  // Sticky status
  logic [1:0] mask;    // Mask bits
  logic       irq;     // Interrupt level

  modport unit (input evt, clr, mask_we, mask_wd, output status, mask, irq);
  modport ctrl (output evt, clr, mask_we, mask_wd, input status, mask, irq);
endinterface : rsix_irq_if

// ==== design/rsix_sync.sv ====
`timescale 1ns/1ps
// Two-flop synchroniser for asynchronous pins
module rsix_sync #(
  parameter int W = 1 // Number of bits
) (
  input  wire logic         clk_sys_i, // System clock
  input  wire logic         arst_n_i,  // Async reset, active low
  input  wire logic [W-1:0] d_i,       // Asynchronous input
  output logic      [W-1:0] q_o        // Synchronised output
);
  logic [W-1:0] meta_reg; // First stage, read only by second
  logic [W-1:0] q_reg;    // Second stage

  // Plain two-stage chain
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg <= '0;
      q_reg    <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule : rsix_sync

// ==== design/rsix_irq.sv ====
`timescale 1ns/1ps
// Sticky interrupt status with mask
module rsix_irq (
  input  wire logic clk_sys_i, // System clock
  input  wire logic arst_n_i,  // Async reset, active low
  rsix_irq_if.unit  irq_if     // Event and clear traffic
);
  logic [1:0] stat_reg;  // Sticky status
  logic [1:0] stat_next; // Next status
  logic [1:0] mask_reg;  // Mask, one masks
  logic [1:0] mask_next; // Next mask
  logic       irq_reg;   // Registered interrupt
  logic       irq_next;  // Next interrupt

  // Set beats clear so no event is lost
  always_comb
  begin
    stat_next = (stat_reg & ~irq_if.clr) | irq_if.evt;
    mask_next = irq_if.mask_we ? irq_if.mask_wd : mask_reg;
    irq_next  = |(stat_next & ~mask_next);
  end

  // State registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stat_reg <= 2'h0;
      mask_reg <= 2'h0;
      irq_reg  <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg  <= irq_next;
    end
  end

  assign irq_if.status = stat_reg;
  assign irq_if.mask   = mask_reg;
  assign irq_if.irq    = irq_reg;
endmodule : rsix_irq

// ==== design/rsix_top.sv ====
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "rsix_defines.svh"
// Regulator six control and ON-state configuration bank
module rsix_top
  import rsix_pkg::*;
(
  input  wire logic        clk_sys_i,    // System clock, 10 MHz
  input  wire logic        arst_n_i,     // Async reset, active low
  input  wire logic [15:0] addr_i,       // Register address
  input  wire logic [15:0] wdata_i,      // Write data
  input  wire logic        wr_i,         // Write strobe
  input  wire logic        rd_i,         // Read strobe
  output logic      [15:0] rdata_o,      // Read data, one cycle later
  input  wire logic        hwc1_i,       // Hardware control input 1 pin
  input  wire logic        hwc2_i,       // Hardware control input 2 pin
  input  wire logic        hwen1_i,      // Hardware enable 1 pin
  input  wire logic        hwen2_i,      // Hardware enable 2 pin
  input  wire logic        uv_i,         // Undervoltage comparator
  input  wire logic        seq_on_i,     // Sequencer powering up or on
  input  wire logic [2:0]  timeslot_i,   // Current sequencer timeslot
  input  wire logic        sleep_i,      // Device in SLEEP state
  output logic             reg_en_o,     // Regulator enabled
  output logic             low_power_o,  // Low power mode
  output logic             lp_variant_o, // Low power variant, 1 = 20mA
  output logic             discharge_o,  // Active output discharge
  output logic             switch_o,     // Switch mode
  output logic      [4:0]  vsel_o,       // Applied voltage code
  output logic      [11:0] vout_mv_o,    // Applied level in mV
  output logic             dev_reset_o,  // Device reset request pulse
  output logic             irq_o         // Interrupt, active high
);

  // Voltage code to millivolts
  function automatic logic [11:0] rsix_code_mv(input logic [4:0] code);
    logic [11:0] c;
    c = {7'h00, code};
    if (code < `RSIX_V_KNEE)
      rsix_code_mv = `RSIX_V_BASE_LO + 12'(c * `RSIX_V_STEP_LO);
    else
      rsix_code_mv = `RSIX_V_BASE_HI
                   + 12'((c - {7'h00, `RSIX_V_KNEE}) * `RSIX_V_STEP_HI);
  endfunction : rsix_code_mv

  // Register storage
  logic [15:0] ctrl_reg;     // Control register
  logic [15:0] ctrl_next;    // Next control
  logic [15:0] on_reg;       // ON control register
  logic [15:0] on_next;      // Next ON control
  logic [15:0] slp_reg;      // SLEEP control register
  logic [15:0] slp_next;     // Next SLEEP control
  logic [15:0] rdata_reg;    // Read data
  logic [15:0] rdata_next;   // Next read data

  // Synchronised pins
  logic [4:0]  pins_s;       // hwc1, hwc2, hwen1, hwen2, uv
  logic        uv_d_reg;     // Previous undervoltage level
  logic        uv_rise;      // Undervoltage onset

  // Field views
  rsix_act_t   act;          // Undervoltage action
  logic [1:0]  src;          // Hardware control source
  logic [1:0]  hmode;        // Hardware control behaviour
  logic [2:0]  slot;         // ON slot select
  logic        hwc_act;      // Hardware control asserted
  logic        demand;       // Enable demand from slot

  // Behaviour state
  rsix_state_t st_reg;       // Power state
  rsix_state_t st_next;      // Next power state
  logic        en_next;      // Next enable
  logic        lp_next;      // Next low power
  logic        dis_next;     // Next discharge
  logic [4:0]  vsel_next;    // Next voltage code
  logic        rst_next;     // Next reset pulse
  logic        en_reg;       // Enable output flop
  logic        lp_reg;       // Low power flop
  logic        lpv_reg;      // Variant flop
  logic        dis_reg;      // Discharge flop
  logic        swi_reg;      // Switch mode flop
  logic [4:0]  vsel_reg;     // Voltage code flop
  logic [11:0] mv_reg;       // Millivolt flop
  logic        rst_reg;      // Reset pulse flop

  rsix_irq_if  irq_if ();    // Interrupt unit link

  // Pins cross into the clock domain
  rsix_sync #(
    .W (5)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .d_i       ({hwc1_i, hwc2_i, hwen1_i, hwen2_i, uv_i}),
    .q_o       (pins_s)
  );

  // Sticky status and mask
  rsix_irq u_irq (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .irq_if    (irq_if)
  );

  // Field decode
  always_comb
  begin
    act     = rsix_act_t'(ctrl_reg[`RSIX_ACT_HI:`RSIX_ACT_LO]);
    src     = ctrl_reg[`RSIX_SRC_HI:`RSIX_SRC_LO];
    hmode   = ctrl_reg[`RSIX_HMODE_HI:`RSIX_HMODE_LO];
    slot    = on_reg[`RSIX_SLOT_HI:`RSIX_SLOT_LO];
    uv_rise = pins_s[0] & ~uv_d_reg;
    unique case (src)
      2'h0: hwc_act = 1'b0;
      2'h1: hwc_act = pins_s[4];
      2'h2: hwc_act = pins_s[3];
      2'h3: hwc_act = pins_s[4] | pins_s[3];
    endcase
    unique case (slot)
      3'h0:    demand = 1'b0;
      3'h6:    demand = pins_s[2];
      3'h7:    demand = pins_s[1];
      default: demand = seq_on_i & (timeslot_i >= slot);
    endcase
  end

  // Register writes and read mux
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    on_next    = on_reg;
    slp_next   = slp_reg;
    rdata_next = 16'h0000;
    irq_if.clr     = 2'h0;
    irq_if.mask_we = 1'b0;
    irq_if.mask_wd = wdata_i[1:0];
    if (wr_i)
    begin
      unique case (addr_i)
        `RSIX_ADDR_CTRL:     ctrl_next = wdata_i & `RSIX_CTRL_WMASK;
        `RSIX_ADDR_ON:       on_next   = wdata_i & `RSIX_SLOT_WMASK;
        `RSIX_ADDR_SLEEP:    slp_next  = wdata_i & `RSIX_SLOT_WMASK;
        `RSIX_ADDR_IRQ_STAT: irq_if.clr = wdata_i[1:0];
        `RSIX_ADDR_IRQ_MASK: irq_if.mask_we = 1'b1;
        default:             ctrl_next = ctrl_reg; // Unmapped, ignored
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        `RSIX_ADDR_CTRL:     rdata_next = ctrl_reg;
        `RSIX_ADDR_ON:       rdata_next = on_reg;
        `RSIX_ADDR_SLEEP:    rdata_next = slp_reg;
        `RSIX_ADDR_IRQ_STAT: rdata_next = {14'h0000, irq_if.status};
        `RSIX_ADDR_IRQ_MASK: rdata_next = {14'h0000, irq_if.mask};
        default:             rdata_next = 16'h0000; // Unmapped reads zero
      endcase
    end
  end

  // Register bank flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_reg  <= `RSIX_CTRL_RST;
      on_reg    <= `RSIX_ON_RST;
      slp_reg   <= `RSIX_SLEEP_RST;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      on_reg    <= on_next;
      slp_reg   <= slp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Interrupt events: bit 0 undervoltage, bit 1 regulator tripped
  always_comb
  begin
    irq_if.evt[0] = uv_rise;
    irq_if.evt[1] = (st_reg != RSIX_TRIPPED) && (st_next == RSIX_TRIPPED);
  end

  // Power state and applied settings
  always_comb
  begin
    st_next   = st_reg;
    rst_next  = 1'b0;
    // Base: ON state settings
    lp_next   = on_reg[`RSIX_MODE_BIT];
    vsel_next = on_reg[`RSIX_VSEL_HI:`RSIX_VSEL_LO];
    en_next   = demand;
    // Sleep state takes the sleep register
    if (sleep_i)
    begin
      lp_next   = slp_reg[`RSIX_MODE_BIT];
      vsel_next = slp_reg[`RSIX_VSEL_HI:`RSIX_VSEL_LO];
    end
    if (hwc_act)
    begin
      vsel_next = ctrl_reg[`RSIX_HVSEL_BIT]
                ? slp_reg[`RSIX_VSEL_HI:`RSIX_VSEL_LO]
                : on_reg[`RSIX_VSEL_HI:`RSIX_VSEL_LO];
      unique case (hmode)
        2'h1: en_next = 1'b0;
        2'h3: lp_next = on_reg[`RSIX_MODE_BIT];
        default: lp_next = 1'b1;
      endcase
    end
    if (uv_rise)
    begin
      unique case (act)
        RSIX_ACT_SHUT:  st_next = RSIX_TRIPPED;
        RSIX_ACT_RESET: rst_next = 1'b1;
        default:        rst_next = 1'b0;
      endcase
    end
    // Trip holds until software rewrites the ON register
    if (st_next == RSIX_TRIPPED)
    begin
      if (st_reg == RSIX_TRIPPED && wr_i && addr_i == `RSIX_ADDR_ON)
        st_next = RSIX_OFF;
      else
        en_next = 1'b0;
    end
    if (st_next != RSIX_TRIPPED)
      st_next = en_next ? RSIX_ON : RSIX_OFF;
    dis_next = ~en_next & ~ctrl_reg[`RSIX_FLT_BIT];
  end

  // Output flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg   <= RSIX_OFF;
      uv_d_reg <= 1'b0;
      en_reg   <= 1'b0;
      lp_reg   <= 1'b0;
      lpv_reg  <= 1'b0;
      dis_reg  <= 1'b1;
      swi_reg  <= 1'b0;
      vsel_reg <= 5'h00;
      mv_reg   <= `RSIX_V_BASE_LO;
      rst_reg  <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      uv_d_reg <= pins_s[0];
      en_reg   <= en_next;
      lp_reg   <= lp_next;
      // variant applies to every low power use
      lpv_reg  <= ctrl_reg[`RSIX_LPV_BIT];
      dis_reg  <= dis_next;
      swi_reg  <= ctrl_reg[`RSIX_SWI_BIT];
      vsel_reg <= vsel_next;
      mv_reg   <= rsix_code_mv(vsel_next);
      rst_reg  <= rst_next;
    end
  end

  // Ports from flops
  assign rdata_o      = rdata_reg;
  assign reg_en_o     = en_reg;
  assign low_power_o  = lp_reg;
  assign lp_variant_o = lpv_reg;
  assign discharge_o  = dis_reg;
  assign switch_o     = swi_reg;
  assign vsel_o       = vsel_reg;
  assign vout_mv_o    = mv_reg;
  assign dev_reset_o  = rst_reg;
  assign irq_o        = irq_if.irq;

endmodule : rsix_top

// ==== dv/rsix_top_monitor.sv ====
`timescale 1ns/1ps
// Port-level checker for the regulator six bank
module rsix_monitor (
  input wire logic        clk_sys_i,   // Clock
  input wire logic        arst_n_i,    // Reset, active low
  input wire logic        wr_i,        // Write strobe
  input wire logic        rd_i,        // Read strobe
  input wire logic [15:0] rdata_o,     // Read data
  input wire logic        uv_i,        // Undervoltage pin
  input wire logic        reg_en_o,    // Regulator enable
  input wire logic        discharge_o, // Discharge request
  input wire logic [4:0]  vsel_o,      // Applied code
  input wire logic [11:0] vout_mv_o,   // Applied level
  input wire logic        dev_reset_o, // Reset request
  input wire logic        irq_o        // Interrupt
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  // Undervoltage onset, then held high long enough to pass the sync delay
  sequence uv_onset;
    !uv_i ##1 uv_i;
  endsequence
  sequence uv_held;
    uv_onset ##1 uv_i [*6];
  endsequence

  // Read data stands only in the cycle after a read
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside its cycle");
  chk_en_no_discharge: assert property (reg_en_o |-> !discharge_o)
    else $error("discharge while enabled");
  chk_vout_map: assert property (vout_mv_o == ((vsel_o < 5'h0f) ?
      12'd900 + 12'd50 * vsel_o : 12'd1700 + 12'd100 * (vsel_o - 5'h0f)))
    else $error("level does not match code");
  chk_pulse_once: assert property (dev_reset_o |=> !dev_reset_o)
    else $error("reset request longer than one cycle");
  chk_pulse_cause: assert property (dev_reset_o |-> $past(uv_i, 3) || $past(uv_i, 4))
    else $error("reset request without undervoltage");
  // A held comparator must not give a second event
  chk_uv_single: assert property (uv_held |-> !dev_reset_o)
    else $error("repeated reset request");
  chk_irq_cause: assert property ($rose(irq_o) |-> $past(uv_i, 3) || $past(uv_i, 4)
      || $past(uv_i, 5) || $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt rose without cause");
  chk_irq_clear: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt fell without a write");
endmodule : rsix_monitor

bind rsix_top rsix_monitor mon_u (.clk_sys_i, .arst_n_i, .wr_i, .rd_i, .rdata_o, .uv_i,
  .reg_en_o, .discharge_o, .vsel_o, .vout_mv_o, .dev_reset_o, .irq_o);

// ==== dv/test_regulator_six_control_regs.sv ====
`timescale 1ns/1ps
`include "rsix_defines.svh"
module test_regulator_six_control_regs;
  localparam logic [15:0] A_CT = `RSIX_ADDR_CTRL;     // Control register
  localparam logic [15:0] A_ON = `RSIX_ADDR_ON;       // ON register
  localparam logic [15:0] A_SL = `RSIX_ADDR_SLEEP;    // Sleep register
  localparam logic [15:0] A_ST = `RSIX_ADDR_IRQ_STAT; // Status register
  localparam logic [15:0] A_MK = `RSIX_ADDR_IRQ_MASK; // Mask register
  logic        clk_sys_i, arst_n_i, wr_i, rd_i;       // Clock, reset, strobes
  logic [15:0] addr_i, wdata_i, rdata_o;               // Register bus
  logic        hwc1_i, hwc2_i, hwen1_i, hwen2_i, uv_i; // Pins
  logic        seq_on_i, sleep_i;                      // Sequencer state
  logic [2:0]  timeslot_i;                             // Current timeslot
  logic        reg_en_o, low_power_o, lp_variant_o;    // Regulator controls
  logic        discharge_o, switch_o, dev_reset_o, irq_o;
  logic [4:0]  vsel_o;                                 // Applied code
  logic [11:0] vout_mv_o;                              // Applied level
  int          n_mismatch, total_checks, n_pulse;      // Counters

  rsix_top dut_u (.clk_sys_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .hwc1_i, .hwc2_i, .hwen1_i, .hwen2_i, .uv_i, .seq_on_i, .timeslot_i, .sleep_i,
    .reg_en_o, .low_power_o, .lp_variant_o, .discharge_o, .switch_o, .vsel_o,
    .vout_mv_o, .dev_reset_o, .irq_o);

  // Free-running 10 MHz clock
  always #50 clk_sys_i = ~clk_sys_i;

  // Count reset request pulses
  always @(posedge clk_sys_i)
  begin
    if (dev_reset_o === 1'b1)
      n_pulse++;
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Let n edges pass, then sample settled outputs
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wt

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    cmp(what, exp, rdata_o);
  endtask : rd

  // Level in millivolts for a voltage code
  function automatic logic [15:0] mv(input logic [4:0] c);
    return (c < 5'h0f) ? 16'd900 + 16'd50 * c : 16'd1700 + 16'd100 * (c - 5'h0f);
  endfunction : mv

  task automatic t_regs;
    cmp("discharge", 16'h0001, {15'h0, discharge_o});
    cmp("vout", 16'd900, {4'h0, vout_mv_o});
    rd(A_CT, 16'h0200, "ctrl");
    rd(A_ON, 16'h0000, "on");
    rd(A_SL, 16'h0100, "sleep");
    rd(16'h4082, 16'h0000, "unmapped");
    wr(A_CT, 16'hffff);
    rd(A_CT, 16'hdfc1, "ctrl bits");
    wr(A_ON, 16'hffff);
    rd(A_ON, 16'he11f, "on bits");
    wr(A_CT, 16'h0200);
  endtask : t_regs

  task automatic t_volt;
    for (int c = 0; c < 32; c++)
    begin
      wr(A_ON, 16'h2000 | 16'(c));
      wt(3);
      cmp("vsel", 16'(c), {11'h0, vsel_o});
      cmp("vout", mv(5'(c)), {4'h0, vout_mv_o});
    end
    wr(A_SL, 16'h011e);
    sleep_i <= 1'b1;
    wt(3);
    cmp("sleep vsel", 16'h001e, {11'h0, vsel_o});
    sleep_i <= 1'b0;
  endtask : t_volt

  task automatic t_slot;
    logic exp;
    timeslot_i <= 3'h3;
    hwen1_i    <= 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      exp = (s >= 1 && s <= 3) || s == 6;
      wr(A_ON, 16'(s) << 13);
      wt(4);
      cmp("enable", {15'h0, exp}, {15'h0, reg_en_o});
      cmp("discharge", {15'h0, !exp}, {15'h0, discharge_o});
    end
    wr(A_CT, 16'h0280);
    wt(3);
    cmp("float", 16'h0000, {15'h0, discharge_o});
    timeslot_i <= 3'h5;
  endtask : t_slot

  task automatic t_hwc;
    logic act;
    wr(A_SL, 16'h011f);
    wr(A_ON, 16'h2005);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 16; c++)
      begin
        hwc1_i <= (p == 0);
        hwc2_i <= (p == 1);
        act = c[2 + p];
        wr(A_CT, (16'(c[3:2]) << 11) | (16'(c[1:0]) << 8) | 16'h0441);
        wt(4);
        cmp("hw vsel", act ? 16'h001f : 16'h0005, {11'h0, vsel_o});
        cmp("hw en", {15'h0, !(act && c[1:0] == 1)}, {15'h0, reg_en_o});
        if (c[1:0] != 1)
          cmp("hw lp", {15'h0, act && c[1:0] != 3}, {15'h0, low_power_o});
        cmp("variant", 16'h0001, {15'h0, lp_variant_o});
        cmp("switch", 16'h0001, {15'h0, switch_o});
      end
    wr(A_CT, 16'h0200);
    wr(A_ON, 16'h2105);
    wt(3);
    cmp("on mode", 16'h0001, {15'h0, low_power_o});
  endtask : t_hwc

  task automatic t_uv;
    for (int a = 0; a < 5; a++)
    begin
      wr(A_MK, (a == 4) ? 16'h0003 : 16'h0000);
      wr(A_CT, 16'(a % 4) << 14 | 16'h0200);
      n_pulse = 0;
      uv_i <= 1'b1;
      wt(8);
      cmp("pulses", (a == 2) ? 16'h0001 : 16'h0000, 16'(n_pulse));
      cmp("irq", (a == 4) ? 16'h0000 : 16'h0001, {15'h0, irq_o});
      cmp("en", (a == 1) ? 16'h0000 : 16'h0001, {15'h0, reg_en_o});
      rd(A_ST, (a == 1) ? 16'h0003 : 16'h0001, "status");
      uv_i <= 1'b0;
      wr(A_ST, 16'h0003);
      wr(A_ON, 16'h2005);
      wt(3);
      cmp("irq clear", 16'h0000, {15'h0, irq_o});
    end
  endtask : t_uv

  task automatic final_report;
    if (n_mismatch == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Hang guard
  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial
  begin
    {clk_sys_i, arst_n_i, wr_i, rd_i, hwc1_i, hwc2_i, hwen1_i, hwen2_i} = '0;
    {uv_i, sleep_i, addr_i, wdata_i} = '0;
    seq_on_i   = 1'b1;
    timeslot_i = 3'h5;
    repeat (6) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    wt(1);
    t_regs();
    t_volt();
    t_slot();
    t_hwc();
    t_uv();
    final_report();
  end
endmodule : test_regulator_six_control_regs
